// ---- dv/gpio_direction_set_clear_assertions.sv ----
// Port checker of the pin direction block
module gpio_dsc_checker
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [27:0] i_pin_in,
  input wire logic [27:0] o_pin_out,
  input wire logic [27:0] o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  oe_reset_clear_a: assert property ($rose(i_reset_n) |-> o_pin_oe == 28'h0)
    else $error("oe not clear");
  dir_write_a: assert property (i_wr && i_addr == 8'h00 |=> o_pin_oe == 28'($past(i_wdata)))
    else $error("dir write");
  dir_hold_a: assert property (!(i_wr && i_addr == 8'h00) |=> $stable(o_pin_oe))
    else $error("dir moved");
  set_bits_a: assert property (i_wr && i_addr == 8'h04 |=> o_pin_out == ($past(o_pin_out) | 28'($past(i_wdata))))
    else $error("set");
  clear_bits_a: assert property (i_wr && i_addr == 8'h08 |=> o_pin_out == ($past(o_pin_out) & ~28'($past(i_wdata))))
    else $error("clear");
  latch_hold_a: assert property (!(i_wr && i_addr inside {8'h04, 8'h08}) |=> $stable(o_pin_out))
    else $error("latch moved");
  dir_read_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == {4'h0, $past(o_pin_oe)})
    else $error("dir read");
  level_read_a: assert property (i_rd && i_addr == 8'h0c && $past(i_reset_n, 2) |=> o_rdata == {4'h0, $past(i_pin_in, 3)})
    else $error("level read");
endmodule
bind gpio_direction_set_clear gpio_dsc_checker gpio_dsc_checker_inst (.*);

// ---- dv/gpio_direction_set_clear_tb_top.sv ----
// Testbench of the pin direction, set and clear block
module gpio_direction_set_clear_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [27:0] i_pin_in, o_pin_out, o_pin_oe;
  logic [27:0] ext_en = 28'h0;
  logic [27:0] ext_val = 28'h0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  gpio_direction_set_clear gpio_direction_set_clear_inst (.*);
  gpio_pad_model gpio_pad_model_inst (.i_clk_sys(i_clk_sys), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(i_pin_in));
  task automatic summarize(bit t);
    n_mismatch += t;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk_sys);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(negedge i_clk_sys);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string n);
    @(posedge i_clk_sys);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(n, o_rdata, exp);
  endtask
  always @(posedge i_clk_sys) if (++cyc == 3000) summarize(1);
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0, "dir reset");
    wr(8'h00, 32'hffffffff);
    rd(8'h00, 32'h0fffffff, "dir ones");
    wr(8'h10, 32'h0);
    rd(8'h00, 32'h0fffffff, "dir kept");
    $display("test direction done");
    wr(8'h00, 32'h000000ff);
    chk("oe", {4'h0, o_pin_oe}, 32'h000000ff);
    wr(8'h08, 32'hffffffff);
    wr(8'h04, 32'hf00000a5);
    chk("set", {4'h0, o_pin_out}, 32'h000000a5);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h00000005);
    chk("clear", {4'h0, o_pin_out}, 32'h000000a0);
    wr(8'h04, 32'h00000100);
    rd(8'h04, 32'h0, "set read");
    ext_val = 28'ha5a5a00;
    ext_en = 28'hfffff20;
    repeat (3) @(posedge i_clk_sys);
    rd(8'h0c, 32'h0a5a5a80, "level");
    $display("test set clear level done");
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0, "dir rereset");
    chk("oe rereset", {4'h0, o_pin_oe}, 32'h0);
    $display("test reset done");
    summarize(0);
  end
endmodule

// ---- dv/gpio_pad_model.sv ----
// Pads with external drivers: fights, driven and floating pins
module gpio_pad_model
(
  input  wire logic        i_clk_sys,
  input  wire logic [27:0] i_out,
  input  wire logic [27:0] i_oe,
  input  wire logic [27:0] i_ext_en,
  input  wire logic [27:0] i_ext_val,
  output logic      [27:0] o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [27:0] float_reg = 28'h0;
  always @(posedge i_clk_sys) float_reg <= ~float_reg;
  // External driver wins a fight; an undriven pin wanders
  assign o_pad = (i_ext_en & i_ext_val) | (~i_ext_en & i_oe & i_out) | (~i_ext_en & ~i_oe & float_reg);
endmodule

// ---- rtl/gpio_ctl_if.sv ----
// Carrier between the register decoder and the direction and output latch store
interface gpio_ctl_if;
  import gpio_direction_pkg::*;
  logic     dir_wr;
  pin_vec_t dir_wdata;
  pin_vec_t set_mask;
  pin_vec_t clr_mask;
  pin_vec_t dir;
  pin_vec_t latch;
  modport ctl
  (
    output dir_wr, dir_wdata, set_mask, clr_mask,
    input  dir, latch
  );
  modport store
  (
    input  dir_wr, dir_wdata, set_mask, clr_mask,
    output dir, latch
  );
endinterface

// ---- rtl/gpio_dir_store.sv ----
// Direction register and hidden output latch
`include "gpio_direction_map.svh"

module gpio_dir_store
  import gpio_direction_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  gpio_ctl_if.store bus
);

  pin_vec_t dir_reg;
  pin_vec_t dir_next;
  pin_vec_t latch_reg;
  pin_vec_t latch_next;

  assign dir_next   = bus.dir_wr ? bus.dir_wdata : dir_reg;
  // Latch follows set and clear whatever the direction; it only reaches the pad when driven
  assign latch_next = (latch_reg | bus.set_mask) & ~bus.clr_mask;

  // The hardware reset input clears the direction bits; a direction write clears those written as zero
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      dir_reg   <= `GPIO_DIR_RESET;
      latch_reg <= `GPIO_LATCH_RESET;
    end
    else
    begin
      dir_reg   <= dir_next;
      latch_reg <= latch_next;
    end
  end

  assign bus.dir   = dir_reg;
  assign bus.latch = latch_reg;

endmodule

// ---- rtl/gpio_direction_map.svh ----
// Register offsets, field limits, reset values and timing counts of the pin direction block
`ifndef GPIO_DIRECTION_MAP_SVH
`define GPIO_DIRECTION_MAP_SVH

`define GPIO_PIN_COUNT      28
`define GPIO_DATA_WIDTH     32
`define GPIO_ADDR_WIDTH     8
`define GPIO_OFS_DIRECTION  8'h00
`define GPIO_OFS_OUT_SET    8'h04
`define GPIO_OFS_OUT_CLEAR  8'h08
`define GPIO_OFS_LEVEL      8'h0c
`define GPIO_DIR_RESET      28'h0000000
`define GPIO_LATCH_RESET    28'h0000000
`define GPIO_SYNC_STAGES    2

`endif

// ---- rtl/gpio_direction_pkg.sv ----
// Types shared by the pin direction block
package gpio_direction_pkg;
  typedef logic [27:0] pin_vec_t;
  typedef enum logic [2:0]
  {
    SEL_NONE      = 3'h0,
    SEL_DIRECTION = 3'h1,
    SEL_OUT_SET   = 3'h3,
    SEL_OUT_CLEAR = 3'h2,
    SEL_LEVEL     = 3'h6
  } reg_sel_e;
endpackage

// ---- rtl/gpio_direction_set_clear.sv ----
// Top of the general-purpose pin direction, set and clear block
`include "gpio_direction_map.svh"

// ==========================================================
module gpio_direction_set_clear
  import gpio_direction_pkg::*;
(
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  input  wire logic [`GPIO_ADDR_WIDTH-1:0] i_addr,
  input  wire logic [`GPIO_DATA_WIDTH-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [`GPIO_DATA_WIDTH-1:0] o_rdata,
  input  wire logic [`GPIO_PIN_COUNT-1:0]  i_pin_in,
  output logic      [`GPIO_PIN_COUNT-1:0]  o_pin_out,
  output logic      [`GPIO_PIN_COUNT-1:0]  o_pin_oe
);

  // ==========================================================
  // Address decode
  reg_sel_e                      sel;
  logic                          hit_dir;
  logic                          hit_set;
  logic                          hit_clr;
  logic                          hit_lvl;
  pin_vec_t                      wr_pins;
  pin_vec_t                      level_sync;
  logic [`GPIO_DATA_WIDTH-1:0]   rdata_reg;
  logic [`GPIO_DATA_WIDTH-1:0]   rdata_next;
  pin_vec_t                      oe_reg;
  pin_vec_t                      out_reg;

  gpio_ctl_if ctl ();

  assign hit_dir = (i_addr == `GPIO_OFS_DIRECTION);
  assign hit_set = (i_addr == `GPIO_OFS_OUT_SET);
  assign hit_clr = (i_addr == `GPIO_OFS_OUT_CLEAR);
  assign hit_lvl = (i_addr == `GPIO_OFS_LEVEL);
  assign sel     = hit_dir ? SEL_DIRECTION :
                   hit_set ? SEL_OUT_SET   :
                   hit_clr ? SEL_OUT_CLEAR :
                   hit_lvl ? SEL_LEVEL     : SEL_NONE;

  // Upper data bits never reach any store
  assign wr_pins = i_wdata[`GPIO_PIN_COUNT-1:0];

  // ==========================================================
  // Write side toward the store
  assign ctl.dir_wr    = i_wr && (sel == SEL_DIRECTION);
  assign ctl.dir_wdata = wr_pins;
  assign ctl.set_mask  = (i_wr && (sel == SEL_OUT_SET))   ? wr_pins : '0;
  assign ctl.clr_mask  = (i_wr && (sel == SEL_OUT_CLEAR)) ? wr_pins : '0;

  gpio_dir_store u_store
  (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .bus       (ctl)
  );

  // ==========================================================
  // Pad sampling
  gpio_pin_sync #(
    .WIDTH  (`GPIO_PIN_COUNT),
    .STAGES (`GPIO_SYNC_STAGES)
  ) u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   (i_pin_in),
    .o_sync    (level_sync)
  );

  // ==========================================================
  // Read side: set, clear and unmapped read zero; the latch has no read path
  always_comb
  begin
    rdata_next = '0;
    if (i_rd)
    begin
      case (sel)
        SEL_DIRECTION: rdata_next = {4'h0, ctl.dir};
        SEL_LEVEL:     rdata_next = {4'h0, level_sync};
        SEL_OUT_SET:   rdata_next = '0;
        SEL_OUT_CLEAR: rdata_next = '0;
        default:       rdata_next = '0;
      endcase
    end
  end

  // ==========================================================
  // Output flops; latch value reaches the pad only where enabled
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_reg <= '0;
      oe_reg    <= `GPIO_DIR_RESET;
      out_reg   <= `GPIO_LATCH_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
      oe_reg    <= ctl.dir_wr ? ctl.dir_wdata : ctl.dir;
      out_reg   <= (ctl.latch | ctl.set_mask) & ~ctl.clr_mask;
    end
  end

  assign o_rdata   = rdata_reg;
  assign o_pin_oe  = oe_reg;
  assign o_pin_out = out_reg;

endmodule

// ---- rtl/gpio_pin_sync.sv ----
// Multi-stage synchroniser bringing pad levels into the system clock domain
`include "gpio_direction_map.svh"

module gpio_pin_sync
  import gpio_direction_pkg::*;
#(
  parameter int WIDTH  = `GPIO_PIN_COUNT,
  parameter int STAGES = `GPIO_SYNC_STAGES
)
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_reg [STAGES];

  // Only the next stage reads each stage; the last one is the output
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int k = 0; k < STAGES; k++)
        stage_reg[k] <= '0;
    end
    else
    begin
      stage_reg[0] <= i_async;
      for (int k = 1; k < STAGES; k++)
        stage_reg[k] <= stage_reg[k-1];
    end
  end

  assign o_sync = stage_reg[STAGES-1];

endmodule
